// File: shared/acd_defs.vh
// Constants for the command decoder and register map of the converter.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef ACD_DEFS_VH
`define ACD_DEFS_VH

// Command byte fields.
`define ACD_CMD_START      7
`define ACD_CMD_CLASS      6
`define ACD_CMD_ZERO       5
`define ACD_CMD_CAL_HI     5
`define ACD_CMD_CAL_LO     4
`define ACD_CMD_PD         3
`define ACD_CMD_SEL_HI     4
`define ACD_CMD_SEL_LO     1
`define ACD_CMD_RD         0

// Calibration type codes.
`define ACD_CAL_SELF       2'h1
`define ACD_CAL_SYS_OFS    2'h2
`define ACD_CAL_SYS_GAIN   2'h3

// Register select codes.
`define ACD_REG_STATUS     4'h0
`define ACD_REG_CFG1       4'h1
`define ACD_REG_CFG2       4'h2
`define ACD_REG_CFG3       4'h3
`define ACD_REG_DATA       4'h4
`define ACD_REG_SYS_OFS    4'h5
`define ACD_REG_SYS_GAIN   4'h6
`define ACD_REG_CHIP_OFS   4'h7
`define ACD_REG_CHIP_GAIN  4'h8

// Reset values.
`define ACD_RST_STATUS     8'h00
`define ACD_RST_CFG1       8'h02
`define ACD_RST_CFG2       8'h0f
`define ACD_RST_CFG3       8'h1e
`define ACD_RST_WORD       24'h00_0000

// Largest chip gain coefficient, just under two.
`define ACD_GAIN_MAX       24'hff_ffff

// Status bit positions.
`define ACD_ST_OVF         7
`define ACD_ST_RATE_HI     6
`define ACD_ST_RATE_LO     4
`define ACD_ST_OVER        3
`define ACD_ST_UNDER       2
`define ACD_ST_BUSY        1
`define ACD_ST_RDY         0

// Gain code position in the third configuration register.
`define ACD_GAIN_HI        7
`define ACD_GAIN_LO        5

// Data phase last bit indices, one less than the lengths in bits.
`define ACD_LEN_BYTE       5'h07
`define ACD_LEN_WORD       5'h17

`endif

// File: rtl/acd_coef_mem.v
// Four 24-bit correction coefficients with one write port and a registered read.
// Assumes the parent arbitrates writers and waits one clock for read data.
`include "acd_defs.vh"

module acd_coef_mem #(
	parameter WIDTH = 24,
	parameter DEPTH = 4
) (
	input  wire             clk_in,      // System clock.
	input  wire             rstn_in,     // Asynchronous reset, active low.
	input  wire             we_in,       // Write strobe, one cycle.
	input  wire [1:0]       waddr_in,    // Write entry.
	input  wire [WIDTH-1:0] wdata_in,    // Write data.
	input  wire [1:0]       raddr_in,    // Read entry.
	output reg  [WIDTH-1:0] rdata_out    // Read data, one clock after the address.
);

	// Entry storage, flops so that every coefficient resets to zero.
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];

	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
			// Each entry takes the write data when it is addressed.
			always @(posedge clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					mem_q[i] <= `ACD_RST_WORD;
				end else if (we_in && (waddr_in == i)) begin
					mem_q[i] <= wdata_in;
				end
			end
		end
	endgenerate

	// Registered read keeps the output path a clean flop.
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_out <= `ACD_RST_WORD;
		end else begin
			rdata_out <= mem_q[raddr_in];
		end
	end

endmodule // acd_coef_mem

// File: rtl/acd_cmd_decode.v
// Serial command decoder, register map and status keeper of the converter.
// Assumes the modulator engine runs on clk_in and reports with one-cycle pulses.
//
// Function
// - Class bit 0 means action request.
// - Class bit 1 means register access.
// - Calibration type 01/10/11 picks calibration kind.
// - Rate code starts conversion at eight rates.
// - Select codes 0 to 8 map registers.
// - Register widths and power-on values as listed.
// - Status read-only, fixed eight-bit layout.
// - Gain code bits 7:5, inert without gain.
// - Gain calibration overflow sets flag, caps coefficient.
// - Status rate is rate of last finished conversion or calibration.
// - Overrange flag follows clipped high result.
// - Underrange flag follows clipped low result.
// - Busy flag while modulator converts or calibrates.
// - Ready flag sets when result is stored.
// - Data read clears ready after next start.
// - Read during conversion clears ready at once.
// - Command byte: start bit, class, fields.
// - Input bits sampled on rising clock, select low.
// - Both directions most significant bit first.
// - Writes to data register are ignored.
`include "acd_defs.vh"

module acd_cmd_decode #(
	parameter HAS_PGA = 1  // Set to 0 for the variant without programmable gain.
) (
	input  wire        clk_in,          // System clock, 100 MHz.
	input  wire        rstn_in,         // Asynchronous reset, active low.
	input  wire        sclk_in,         // Serial clock pin from the host.
	input  wire        csn_in,          // Chip select pin, active low.
	input  wire        din_in,          // Serial data in pin.
	output reg         dout_out,        // Serial data out / ready pin value.
	output reg         dout_oen_out,    // Output enable of dout, low while driving.
	input  wire        conv_done_in,    // Conversion finished pulse.
	input  wire [23:0] conv_result_in,  // Clipped result, valid with conv_done_in.
	input  wire        conv_over_in,    // Result was clipped high.
	input  wire        conv_under_in,   // Result was clipped low.
	input  wire        cal_done_in,     // Calibration finished pulse.
	input  wire        cal_overflow_in, // Gain calibration ran out of range.
	output reg         start_conv_out,  // Start conversion pulse.
	output reg  [2:0]  conv_rate_out,   // Rate code of the started conversion.
	output reg         start_cal_out,   // Start calibration pulse.
	output reg  [1:0]  cal_type_out,    // Calibration kind of the started cycle.
	output reg         power_down_out,  // Immediate power-down pulse.
	output reg  [7:0]  cfg1_out,        // First configuration register.
	output reg  [7:0]  cfg2_out,        // GPIO configuration register.
	output reg  [7:0]  cfg3_out,        // Third configuration register.
	output reg  [2:0]  digital_gain_out // Effective digital gain code.
);

	// One-hot phases of the serial frame.
	localparam [1:0] PH_CMD  = 2'b01;
	localparam [1:0] PH_DATA = 2'b10;

	// Pin synchronisers; the first stage feeds only the second.
	reg        sclk_s1_q, sclk_s2_q, sclk_s3_q;
	reg        csn_s1_q, csn_s2_q;
	reg        din_s1_q, din_s2_q;

	// Serial engine state.
	reg [1:0]  ph_q;              // Frame phase.
	reg [4:0]  cnt_q;             // Bits taken in this phase.
	reg [23:0] rx_q;              // Receive shifter.
	reg [23:0] tx_q;              // Transmit shifter, left aligned.
	reg [3:0]  sel_q;             // Register select of the access.
	reg        rd_q;              // Access is a read.
	reg [4:0]  len_q;             // Last bit index of the data phase.
	reg [1:0]  ld_q;              // Read data load pipeline.

	// Register map contents.
	reg [23:0] data_q;            // Conversion result.
	reg        ovf_q;             // Gain calibration overflow flag.
	reg [2:0]  rate_st_q;         // Rate of the last finished conversion or calibration.
	reg        over_q, under_q;   // Clip flags.
	reg        busy_q;            // Modulator busy.
	reg        conv_run_q;        // A conversion, not a calibration, runs.
	reg        rdy_q;             // Result ready.
	reg        read_seen_q;       // Result was read while idle.
	reg [2:0]  run_rate_q;        // Rate of the cycle in progress.
	reg        gcal_q;            // Running cycle is a system gain calibration.

	// Decoded pulses of this cycle.
	reg        act_conv, act_cal, act_pd, wr_go, data_rd_done;
	reg [7:0]  cmd_b;

	wire        sclk_rise = sclk_s2_q & ~sclk_s3_q & ~csn_s2_q;
	wire        sclk_fall = ~sclk_s2_q & sclk_s3_q & ~csn_s2_q;
	wire [23:0] rx_next   = {rx_q[22:0], din_s2_q};
	wire [7:0]  status_w  = {ovf_q, rate_st_q, over_q, under_q, busy_q, rdy_q};
	wire        sel_coef  = (sel_q >= `ACD_REG_SYS_OFS) && (sel_q <= `ACD_REG_CHIP_GAIN);
	wire [3:0]  coef_idx  = sel_q - `ACD_REG_SYS_OFS;
	wire [23:0] coef_rd;
	wire        cap_gain  = cal_done_in & gcal_q & cal_overflow_in;

	// A capped gain coefficient has priority over a host write in the same clock.
	wire        mem_we    = cap_gain | (wr_go & sel_coef);
	wire [1:0]  mem_waddr = cap_gain ? 2'h3 : coef_idx[1:0];
	wire [23:0] mem_wdata = cap_gain ? `ACD_GAIN_MAX : rx_next;

	acd_coef_mem #(
		.WIDTH (24),
		.DEPTH (4)
	) u_coef (
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.we_in     (mem_we),
		.waddr_in  (mem_waddr),
		.wdata_in  (mem_wdata),
		.raddr_in  (coef_idx[1:0]),
		.rdata_out (coef_rd)
	);

	// Two flops on each pin; the third sclk stage exists only to find edges.
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			csn_s1_q  <= 1'b1;
			csn_s2_q  <= 1'b1;
			din_s1_q  <= 1'b0;
			din_s2_q  <= 1'b0;
		end else begin
			sclk_s1_q <= sclk_in;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			csn_s1_q  <= csn_in;
			csn_s2_q  <= csn_s1_q;
			din_s1_q  <= din_in;
			din_s2_q  <= din_s1_q;
		end
	end

	// Decode of the frame end points; pure function of the current bit.
	always @* begin
		act_conv     = 1'b0;
		act_cal      = 1'b0;
		act_pd       = 1'b0;
		wr_go        = 1'b0;
		data_rd_done = 1'b0;
		cmd_b        = rx_next[7:0];
		if (sclk_rise) begin
			case (ph_q)
				PH_CMD: begin
					// Bytes without the start bit or with class 1 set no action here.
					if ((cnt_q == `ACD_LEN_BYTE) && cmd_b[`ACD_CMD_START] && !cmd_b[`ACD_CMD_CLASS]) begin
						if (cmd_b[`ACD_CMD_PD]) begin
							act_pd = 1'b1;
						end else if (cmd_b[`ACD_CMD_CAL_HI:`ACD_CMD_CAL_LO] != 2'h0) begin
							act_cal = (cmd_b[2:0] == 3'h0);
						end else begin
							act_conv = 1'b1;
						end
					end
				end
				PH_DATA: begin
					if (cnt_q == len_q) begin
						wr_go        = ~rd_q;
						data_rd_done = rd_q & (sel_q == `ACD_REG_DATA);
					end
				end
				default: begin
					wr_go = 1'b0;
				end
			endcase
		end
	end

	// Serial frame engine: shifts in on rising edges, out on falling edges.
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ph_q         <= PH_CMD;
			cnt_q        <= 5'h00;
			rx_q         <= `ACD_RST_WORD;
			tx_q         <= `ACD_RST_WORD;
			sel_q        <= `ACD_REG_STATUS;
			rd_q         <= 1'b0;
			len_q        <= `ACD_LEN_BYTE;
			ld_q         <= 2'b00;
			dout_out     <= 1'b1;
			dout_oen_out <= 1'b1;
		end else begin
			dout_oen_out <= csn_s2_q;
			ld_q         <= {ld_q[0], 1'b0};
			// Read data waits a clock for the coefficient memory.
			if (ld_q[1]) begin
				case (sel_q)
					`ACD_REG_STATUS: tx_q <= {status_w, 16'h0000};
					`ACD_REG_CFG1:   tx_q <= {cfg1_out, 16'h0000};
					`ACD_REG_CFG2:   tx_q <= {cfg2_out, 16'h0000};
					`ACD_REG_CFG3:   tx_q <= {cfg3_out, 16'h0000};
					`ACD_REG_DATA:   tx_q <= data_q;
					default: begin
						tx_q <= sel_coef ? coef_rd : `ACD_RST_WORD;
					end
				endcase
			end
			if (csn_s2_q) begin
				// A released select abandons any partial byte.
				ph_q  <= PH_CMD;
				cnt_q <= 5'h00;
			end else if (sclk_rise) begin
				rx_q  <= rx_next;
				cnt_q <= cnt_q + 5'h01;
				case (ph_q)
					PH_CMD: begin
						if (cnt_q == `ACD_LEN_BYTE) begin
							cnt_q <= 5'h00;
							if (cmd_b[`ACD_CMD_START] && cmd_b[`ACD_CMD_CLASS] && !cmd_b[`ACD_CMD_ZERO]) begin
								ph_q  <= PH_DATA;
								sel_q <= cmd_b[`ACD_CMD_SEL_HI:`ACD_CMD_SEL_LO];
								rd_q  <= cmd_b[`ACD_CMD_RD];
								ld_q  <= {1'b0, cmd_b[`ACD_CMD_RD]};
								// Word registers take 24 bits, all others a byte.
								if ((cmd_b[4:1] >= `ACD_REG_DATA) && (cmd_b[4:1] <= `ACD_REG_CHIP_GAIN)) begin
									len_q <= `ACD_LEN_WORD;
								end else begin
									len_q <= `ACD_LEN_BYTE;
								end
							end
						end
					end
					PH_DATA: begin
						if (cnt_q == len_q) begin
							ph_q  <= PH_CMD;
							cnt_q <= 5'h00;
						end
					end
					default: begin
						ph_q <= PH_CMD;
					end
				endcase
			end
			// During a read the shifter drives the pin; otherwise the pin shows not-ready.
			if (ph_q == PH_DATA && rd_q) begin
				if (sclk_fall) begin
					dout_out <= tx_q[23];
					tx_q     <= {tx_q[22:0], 1'b0};
				end
			end else begin
				dout_out <= ~rdy_q;
			end
		end
	end

	// Configuration registers; status and data writes fall through unchanged.
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg1_out         <= `ACD_RST_CFG1;
			cfg2_out         <= `ACD_RST_CFG2;
			cfg3_out         <= `ACD_RST_CFG3;
			digital_gain_out <= 3'h0;
		end else if (wr_go) begin
			case (sel_q)
				`ACD_REG_CFG1: cfg1_out <= rx_next[7:0];
				`ACD_REG_CFG2: cfg2_out <= rx_next[7:0];
				`ACD_REG_CFG3: begin
					cfg3_out <= rx_next[7:0];
					// Without the gain stage the code is stored but drives nothing.
					digital_gain_out <= (HAS_PGA != 0) ? rx_next[`ACD_GAIN_HI:`ACD_GAIN_LO] : 3'h0;
				end
				default: begin
					cfg1_out <= cfg1_out;
				end
			endcase
		end
	end

	// Action pulses towards the modulator engine.
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			start_conv_out <= 1'b0;
			start_cal_out  <= 1'b0;
			power_down_out <= 1'b0;
			conv_rate_out  <= 3'h0;
			cal_type_out   <= 2'h0;
		end else begin
			start_conv_out <= act_conv;
			start_cal_out  <= act_cal;
			power_down_out <= act_pd;
			if (act_conv) begin
				conv_rate_out <= cmd_b[2:0];
			end
			if (act_cal) begin
				cal_type_out <= cmd_b[`ACD_CMD_CAL_HI:`ACD_CMD_CAL_LO];
			end
		end
	end

	// Status flags, result register and the ready handshake.
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			data_q      <= `ACD_RST_WORD;
			ovf_q       <= 1'b0;
			rate_st_q   <= 3'h0;
			over_q      <= 1'b0;
			under_q     <= 1'b0;
			busy_q      <= 1'b0;
			conv_run_q  <= 1'b0;
			rdy_q       <= 1'b0;
			read_seen_q <= 1'b0;
			run_rate_q  <= 3'h0;
			gcal_q      <= 1'b0;
		end else begin
			// Busy covers conversions and calibrations alike; power-down ends both.
			if (act_conv || act_cal) begin
				busy_q     <= 1'b1;
				conv_run_q <= act_conv;
				gcal_q     <= act_cal && (cmd_b[5:4] == `ACD_CAL_SYS_GAIN);
			end else if (act_pd || conv_done_in || cal_done_in) begin
				busy_q     <= 1'b0;
				conv_run_q <= 1'b0;
			end
			// Calibration keeps the rate of the last conversion for its coefficients.
			if (act_conv) begin
				run_rate_q <= cmd_b[2:0];
			end
			if (conv_done_in) begin
				data_q    <= conv_result_in;
				rate_st_q <= run_rate_q;
				over_q    <= conv_over_in;
				under_q   <= conv_under_in;
			end
			if (cal_done_in) begin
				rate_st_q <= run_rate_q;
				if (gcal_q) begin
					ovf_q <= cal_overflow_in;
				end
			end
			// A new result beats any clear landing in the same clock.
			if (conv_done_in) begin
				rdy_q       <= 1'b1;
				read_seen_q <= 1'b0;
			end else if (data_rd_done && conv_run_q) begin
				rdy_q       <= 1'b0;
				read_seen_q <= 1'b0;
			end else if (act_conv) begin
				rdy_q       <= rdy_q & ~read_seen_q;
				read_seen_q <= 1'b0;
			end else if (data_rd_done && rdy_q) begin
				read_seen_q <= 1'b1;
			end
		end
	end

endmodule // acd_cmd_decode

// File: bench/acd_cmd_decode_chk.sv
// Concurrent checks on the ports of the command decoder.
// Assumes a bind onto acd_cmd_decode, one clock and a low-active reset.
module acd_cmd_decode_chk #(
	parameter HAS_PGA = 1  // Same gain option as the design.
) (
	input wire       clk_in,
	input wire       rstn_in,
	input wire       csn_in,
	input wire       conv_done_in,
	input wire       dout_out,
	input wire       dout_oen_out,
	input wire       start_conv_out,
	input wire [2:0] conv_rate_out,
	input wire       start_cal_out,
	input wire [1:0] cal_type_out,
	input wire       power_down_out,
	input wire [7:0] cfg1_out,
	input wire [7:0] cfg2_out,
	input wire [7:0] cfg3_out,
	input wire [2:0] digital_gain_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// An idle select must release the output once the synchroniser has caught up.
	property p_oen_idle; csn_in[*4] |-> dout_oen_out; endproperty
	a_oen_idle: assert property (p_oen_idle) else $error("output driven while deselected");
	// A stored result shows as a low ready level within a few clocks.
	property p_rdy_set; conv_done_in && csn_in |-> ##[1:3] !dout_out; endproperty
	a_rdy_set: assert property (p_rdy_set) else $error("ready level missing after result");
	// One command byte asks for one action only.
	property p_excl; start_conv_out |-> !start_cal_out && !power_down_out; endproperty
	a_excl: assert property (p_excl) else $error("two actions at once");
	// A start is a single pulse, since the byte was taken once.
	property p_conv_pulse; start_conv_out |=> !start_conv_out; endproperty
	a_conv_pulse: assert property (p_conv_pulse) else $error("start pulse too long");
	// A calibration never starts with the conversion code.
	property p_cal_type; start_cal_out |-> cal_type_out != 2'b00; endproperty
	a_cal_type: assert property (p_cal_type) else $error("calibration with no kind");
	// The rate level only moves together with a start.
	property p_rate_hold; $changed(conv_rate_out) |-> start_conv_out; endproperty
	a_rate_hold: assert property (p_rate_hold) else $error("rate moved without start");
	// The gain follows the written field, or stays zero on the plain variant.
	property p_gain;
		$changed(cfg3_out) |-> ##[0:1] digital_gain_out == ((HAS_PGA != 0) ? cfg3_out[7:5] : 3'b000);
	endproperty
	a_gain: assert property (p_gain) else $error("gain code mismatch");
	// Without a selected frame no configuration register may change.
	property p_cfg_quiet; csn_in[*5] |-> $stable({cfg1_out, cfg2_out, cfg3_out}); endproperty
	a_cfg_quiet: assert property (p_cfg_quiet) else $error("register moved while idle");
	// A start needs a selected frame shortly before.
	property p_start_csn; start_conv_out |-> !$past(csn_in, 4); endproperty
	a_start_csn: assert property (p_start_csn) else $error("start without frame");
	c_conv: cover property (start_conv_out);
	c_gain_cal: cover property (start_cal_out && cal_type_out == 2'b11);
	c_pd: cover property (power_down_out);
endmodule // acd_cmd_decode_chk

bind acd_cmd_decode acd_cmd_decode_chk #(.HAS_PGA(HAS_PGA)) chk (.clk_in(clk_in), .rstn_in(rstn_in),
	.csn_in(csn_in), .conv_done_in(conv_done_in), .dout_out(dout_out), .dout_oen_out(dout_oen_out),
	.start_conv_out(start_conv_out), .conv_rate_out(conv_rate_out), .start_cal_out(start_cal_out),
	.cal_type_out(cal_type_out), .power_down_out(power_down_out), .cfg1_out(cfg1_out), .cfg2_out(cfg2_out),
	.cfg3_out(cfg3_out), .digital_gain_out(digital_gain_out));

// File: bench/acd_host_model.sv
// Host model that masters the serial link of the converter.
// Assumes the system clock for pacing; a serial half period is eight clocks.
module acd_host_model (
	input  wire  clk_in,   // System clock used to pace the link.
	input  wire  dout_in,  // Serial data from the device.
	output logic sclk_out, // Serial clock, still and low outside frames.
	output logic csn_out,  // Chip select, active low.
	output logic din_out   // Serial data to the device.
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk_out = 1'b0;
		csn_out = 1'b1;
		din_out = 1'b0;
	end
	// Waits whole clocks and then steps off the edge before anything changes.
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// One frame: a command byte, then nb data bits both ways.
	task automatic xfer(input logic [7:0] cmd, input int nb, input logic [23:0] wd, output logic [23:0] rd);
		rd = 24'h00_0000;
		step(1);
		csn_out = 1'b0;
		for (int i = 0; i < 8 + nb; i++) begin
			din_out = (i < 8) ? cmd[7 - i] : wd[nb + 7 - i];
			step(8);
			// Read data changes on the falling edge, so it is taken just before the rise.
			if (i >= 8) rd = {rd[22:0], dout_in};
			sclk_out = 1'b1;
			step(8);
			sclk_out = 1'b0;
		end
		step(8);
		csn_out = 1'b1;
		din_out = ~din_out;
		step(8);
	endtask
endmodule // acd_host_model

// File: bench/adc_command_decode_and_status_bench.sv
// Self-checking bench for the command decoder, register map and status.
// Assumes the host model masters the link and this module plays the modulator.
module adc_command_decode_and_status_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_in = 1'b0;          // System clock.
	logic        rstn_in = 1'b0;         // Reset, active low.
	logic        conv_done_in = 1'b0;    // Engine result pulse.
	logic [23:0] conv_result_in = 24'h00_0000;
	logic        conv_over_in = 1'b0;
	logic        conv_under_in = 1'b0;
	logic        cal_done_in = 1'b0;     // Engine calibration pulse.
	logic        cal_overflow_in = 1'b0;
	wire         sclk_w, csn_w, din_w, dout_out, dout_oen_out;
	wire         start_conv_out, start_cal_out, power_down_out;
	wire  [2:0]  conv_rate_out, digital_gain_out;
	wire  [1:0]  cal_type_out;
	wire  [7:0]  cfg1_out, cfg2_out, cfg3_out;
	wire  [2:0]  plain_gain_w;                // Gain code of the copy without the gain stage.
	wire  [7:0]  plain_cfg3_w;                // Third configuration register of that copy.
	// A released line has no defined value, so the host sees it inverted.
	wire         dout_w = dout_oen_out ? ~dout_out : dout_out;
	int          miscompares = 0, cmp_count = 0, n_conv = 0, n_cal = 0, n_pd = 0;
	logic [23:0] v, pat;
	logic [7:0]  rst_tab [4] = '{8'h00, 8'h02, 8'h0f, 8'h1e};

	acd_cmd_decode uut (.clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk_w), .csn_in(csn_w), .din_in(din_w),
		.dout_out(dout_out), .dout_oen_out(dout_oen_out), .conv_done_in(conv_done_in),
		.conv_result_in(conv_result_in), .conv_over_in(conv_over_in), .conv_under_in(conv_under_in),
		.cal_done_in(cal_done_in), .cal_overflow_in(cal_overflow_in), .start_conv_out(start_conv_out),
		.conv_rate_out(conv_rate_out), .start_cal_out(start_cal_out), .cal_type_out(cal_type_out),
		.power_down_out(power_down_out), .cfg1_out(cfg1_out), .cfg2_out(cfg2_out), .cfg3_out(cfg3_out),
		.digital_gain_out(digital_gain_out));
	acd_host_model host (.clk_in(clk_in), .dout_in(dout_w), .sclk_out(sclk_w), .csn_out(csn_w), .din_out(din_w));
	// A second copy without the gain stage hears the same frames, so the plain variant is exercised too.
	acd_cmd_decode #(.HAS_PGA(0)) uut_plain (.clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk_w),
		.csn_in(csn_w), .din_in(din_w), .dout_out(), .dout_oen_out(), .conv_done_in(conv_done_in),
		.conv_result_in(conv_result_in), .conv_over_in(conv_over_in), .conv_under_in(conv_under_in),
		.cal_done_in(cal_done_in), .cal_overflow_in(cal_overflow_in), .start_conv_out(), .conv_rate_out(),
		.start_cal_out(), .cal_type_out(), .power_down_out(), .cfg1_out(), .cfg2_out(), .cfg3_out(plain_cfg3_w),
		.digital_gain_out(plain_gain_w));

	initial begin
		forever #5 clk_in = ~clk_in;
	end
	// Action pulses are counted as they pass, since each stands one clock.
	always @(posedge clk_in) begin
		n_conv += start_conv_out;
		n_cal += start_cal_out;
		n_pd += power_down_out;
	end
	task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic int nbits(input logic [3:0] s);
		return (s >= 4'h4 && s <= 4'h8) ? 24 : 8;
	endfunction
	task automatic rd(input logic [3:0] s, output logic [23:0] r);
		host.xfer({3'b110, s, 1'b1}, nbits(s), 24'h00_0000, r);
	endtask
	task automatic wr(input logic [3:0] s, input logic [23:0] d);
		logic [23:0] r;
		host.xfer({3'b110, s, 1'b0}, nbits(s), d, r);
	endtask
	task automatic act(input logic [7:0] cmd);
		logic [23:0] r;
		host.xfer(cmd, 0, 24'h00_0000, r);
	endtask
	// Plays the engine: a result or a calibration end, one clock wide.
	task automatic engine(input logic cal, input logic [23:0] r, input logic o, input logic u);
		conv_result_in = r;
		conv_over_in = o;
		conv_under_in = u;
		cal_overflow_in = o;
		conv_done_in = !cal;
		cal_done_in = cal;
		@(posedge clk_in);
		#1;
		conv_done_in = 1'b0;
		cal_done_in = 1'b0;
		repeat (3) @(posedge clk_in);
		#1;
	endtask
	task automatic stat(input logic [7:0] exp);
		rd(4'h0, v);
		chk("status", v, {16'h0000, exp});
	endtask
	task automatic tally_and_finish();
		if (miscompares == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Cuts a hang short at several times the expected run.
	initial begin
		#800_000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (6) @(posedge clk_in);
		#1;
		rstn_in = 1'b1;
		repeat (4) @(posedge clk_in);
		for (int s = 0; s < 9; s++) begin
			rd(s[3:0], v);
			chk("reset", v, (s < 4) ? {16'h0000, rst_tab[s]} : 24'h00_0000);
		end
		// Every writable place takes its own pattern; the result register keeps zero.
		for (int s = 1; s < 9; s++) begin
			pat = 24'ha5_c3b1 ^ s;
			wr(s[3:0], pat);
			rd(s[3:0], v);
			chk("wr_rd", v, (s == 4) ? 24'h00_0000 : (s < 4) ? {16'h0000, pat[7:0]} : pat);
		end
		chk("cfg1", cfg1_out, 8'hb0);
		chk("gain", digital_gain_out, 3'b101);
		chk("cfg2", cfg2_out, 8'hb3);
		chk("cfg3", cfg3_out, 8'hb2);
		chk("plain_gain", plain_gain_w, 3'b000);
		chk("plain_cfg3", plain_cfg3_w, 8'hb2);
		wr(4'h0, 24'h00_00ff);
		stat(8'h00);
		wr(4'h9, 24'h00_00ff);
		rd(4'h9, v);
		chk("sel9", v, 24'h00_0000);
		rd(4'h1, v);
		chk("sel9_keep", v, 24'h00_00b0);
		for (int r = 0; r < 8; r++) begin
			act(8'h80 | r);
			chk("rate", conv_rate_out, r);
			chk("n_conv", n_conv, r + 1);
		end
		stat(8'h02);
		engine(1'b0, 24'h12_3456, 1'b1, 1'b0);
		stat(8'h79);
		rd(4'h4, v);
		chk("data", v, 24'h12_3456);
		stat(8'h79);
		act(8'h82);
		stat(8'h7a);
		engine(1'b0, 24'h00_0001, 1'b0, 1'b1);
		stat(8'h25);
		act(8'h85);
		stat(8'h27);
		rd(4'h4, v);
		chk("data2", v, 24'h00_0001);
		stat(8'h26);
		for (int c = 1; c < 4; c++) begin
			act(8'h80 | (c << 4));
			chk("cal_type", cal_type_out, c);
			engine(1'b1, 24'h00_0000, c == 3, 1'b0);
		end
		chk("n_cal", n_cal, 3);
		stat(8'hd4);
		rd(4'h8, v);
		chk("gain_cap", v, 24'hff_ffff);
		act(8'h91);
		act(8'h08);
		chk("refused", n_cal + n_conv + n_pd, 13);
		act(8'h88);
		chk("n_pd", n_pd, 1);
		tally_and_finish();
	end
endmodule // adc_command_decode_and_status_bench
